// file: core/aad_alu.sv
`timescale 1ns/10ps
`default_nettype none

module aad_alu #(
    parameter int WIDTH = 8
) (
    // Operands
    input wire logic [WIDTH-1:0] acc,
    input wire logic [WIDTH-1:0] opnd,
    input wire logic do_add,
    // Result and flags
    output logic [WIDTH-1:0] result,
    output logic carry,
    output logic nibble_carry,
    output logic zero
);

    wire logic [WIDTH:0] full_sum;
    wire logic [4:0] low_sum;

    assign full_sum = {1'b0, acc} + {1'b0, opnd};
    assign low_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
    assign result = do_add ? full_sum[WIDTH-1:0] : (acc & opnd);
    assign carry = full_sum[WIDTH];
    assign nibble_carry = low_sum[4];
    assign zero = (result == '0);

endmodule : aad_alu
`default_nettype wire

// file: core/aad_core.sv
// Overview of operation
// - An instruction with prefix 11 111x adds its 8-bit literal to the accumulator, stores the sum there and updates carry, nibble carry and zero.
// - An instruction with prefix 11 1001 ANDs the accumulator with its literal, stores the result there and updates only zero.
// - An instruction with prefix 00 0111 adds the accumulator to the addressed 7-bit file register and updates carry, nibble carry and zero.
// - An instruction with prefix 00 0101 ANDs the accumulator with the addressed file register and updates only zero.
// - For the file forms a destination bit of 0 sends the result to the accumulator and 1 writes it back to the file register.
// - Each of these instructions completes in one instruction cycle built from four clock periods.
`timescale 1ns/10ps
`default_nettype none
`include "aad_regs.svh"

module aad_core import aad_pkg::*; #(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 16
) (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction fetch
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    output logic instr_ready,
    // File register port
    output logic [6:0] file_addr,
    output logic file_rd_en,
    input wire logic [7:0] file_rd_data,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    // Execution status
    output logic exec_done
);

    // Phase sequencer
    aad_phase_t phase_ff;
    aad_phase_t nxt_phase;
    logic run_ff;
    logic busy_ff;
    wire logic in_q1;
    wire logic in_q2;
    wire logic in_q3;
    wire logic in_q4;
    wire logic take;
    wire logic nxt_busy;

    assign in_q1 = (phase_ff == AAD_Q1);
    assign in_q2 = (phase_ff == AAD_Q2);
    assign in_q3 = (phase_ff == AAD_Q3);
    assign in_q4 = (phase_ff == AAD_Q4);

    // Only Q1 may stall; a cycle already started always finishes in Q4
    always_comb begin
        case (phase_ff)
            AAD_Q1: nxt_phase = run_ff ? AAD_Q2 : AAD_Q1;
            AAD_Q2: nxt_phase = AAD_Q3;
            AAD_Q3: nxt_phase = AAD_Q4;
            AAD_Q4: nxt_phase = AAD_Q1;
            default: nxt_phase = AAD_Q1;
        endcase
    end

    assign instr_ready = run_ff & in_q1;
    assign take = ce & instr_valid & instr_ready;
    assign nxt_busy = take ? 1'b1 : (in_q4 ? 1'b0 : busy_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= AAD_Q1;
            busy_ff <= 1'b0;
        end else if (ce) begin
            phase_ff <= nxt_phase;
            busy_ff <= nxt_busy;
        end
    end

    // Decode, captured when the word is taken
    aad_op_t dec_op;
    logic dec_dest;
    logic [6:0] dec_addr;
    logic [7:0] dec_lit;

    aad_decode u_decode (
        .instr_word(instr_word),
        .op(dec_op),
        .dest_file(dec_dest),
        .addr(dec_addr),
        .literal(dec_lit)
    );

    aad_op_t op_ff;
    logic dest_ff;
    logic [7:0] lit_ff;
    logic [6:0] file_addr_ff;
    logic file_rd_en_ff;
    wire logic dec_is_file;

    assign dec_is_file = (dec_op == AAD_OP_ADD_FILE) || (dec_op == AAD_OP_AND_FILE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ff <= AAD_OP_NONE;
            dest_ff <= 1'b0;
            lit_ff <= 8'h00;
            file_addr_ff <= 7'h00;
            file_rd_en_ff <= 1'b0;
        end else if (ce) begin
            if (take) begin
                op_ff <= dec_op;
                dest_ff <= dec_dest;
                lit_ff <= dec_lit;
                file_addr_ff <= dec_addr;
                file_rd_en_ff <= dec_is_file;
            end else if (in_q3) begin
                file_rd_en_ff <= 1'b0;
            end
        end
    end

    // Phase gate keeps a stray strobe out of Q4 and Q1 even if the
    // capture logic above is changed later
    wire logic rd_window;

    assign rd_window = in_q2 | in_q3;
    assign file_addr = file_addr_ff;
    assign file_rd_en = file_rd_en_ff & rd_window;

    // Operand: literal or file data sampled at the end of Q3
    wire logic op_is_file;
    wire logic op_is_add;
    wire logic op_valid;
    logic [7:0] opnd_sel;
    logic [7:0] w_ff;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;

    assign op_is_file = (op_ff == AAD_OP_ADD_FILE) || (op_ff == AAD_OP_AND_FILE);
    assign op_is_add = (op_ff == AAD_OP_ADD_LIT) || (op_ff == AAD_OP_ADD_FILE);
    assign op_valid = busy_ff & (op_ff != AAD_OP_NONE);
    assign opnd_sel = op_is_file ? file_rd_data : lit_ff;

    aad_alu #(
        .WIDTH(8)
    ) u_alu (
        .acc(w_ff),
        .opnd(opnd_sel),
        .do_add(op_is_add),
        .result(alu_res),
        .carry(alu_c),
        .nibble_carry(alu_dc),
        .zero(alu_z)
    );

    // Result stage, loaded at the end of Q3
    logic [7:0] res_ff;
    logic res_c_ff;
    logic res_dc_ff;
    logic res_z_ff;
    logic file_wr_en_ff;
    logic exec_done_ff;
    wire logic load_res;
    wire logic nxt_file_wr;

    // Flags travel with the result so a commit never mixes two words
    assign load_res = in_q3 & op_valid;
    assign nxt_file_wr = load_res & op_is_file & dest_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_ff <= 8'h00;
            res_c_ff <= 1'b0;
            res_dc_ff <= 1'b0;
            res_z_ff <= 1'b0;
            file_wr_en_ff <= 1'b0;
            exec_done_ff <= 1'b0;
        end else if (ce) begin
            if (load_res) begin
                res_ff <= alu_res;
                res_c_ff <= alu_c;
                res_dc_ff <= alu_dc;
                res_z_ff <= alu_z;
            end
            file_wr_en_ff <= nxt_file_wr;
            exec_done_ff <= load_res;
        end
    end

    assign file_wr_en = file_wr_en_ff;
    assign file_wr_data = res_ff;
    assign exec_done = exec_done_ff;

    // Commit at the end of Q4
    wire logic commit;
    wire logic commit_w;
    wire logic commit_cdc;

    assign commit = in_q4 & op_valid;
    assign commit_w = commit & ~(op_is_file & dest_ff);
    assign commit_cdc = commit & op_is_add;

    // APB slave; pready follows ce so a frozen block stalls the master
    wire logic apb_done;
    wire logic apb_wr;
    wire logic hit_w;
    wire logic hit_stat;
    wire logic hit_ctrl;
    wire logic hit_ret;
    wire logic hit_any;

    assign apb_done = psel & penable & ce;
    assign apb_wr = apb_done & pwrite & hit_any;
    assign hit_w = (paddr == ADDR_W'(`AAD_OFS_WREG));
    assign hit_stat = (paddr == ADDR_W'(`AAD_OFS_STAT));
    assign hit_ctrl = (paddr == ADDR_W'(`AAD_OFS_CTRL));
    assign hit_ret = (paddr == ADDR_W'(`AAD_OFS_RETIRED));
    assign hit_any = hit_w | hit_stat | hit_ctrl | hit_ret;
    assign pready = ce;
    // Unmapped addresses answer with an error, read as zero and write nothing
    assign pslverr = psel & penable & ~hit_any;

    // Accumulator and flags; the core's commit wins over a software write
    logic flag_c_ff;
    logic flag_dc_ff;
    logic flag_z_ff;
    logic unsup_ff;
    logic [CNT_W-1:0] retired_ff;
    wire logic [7:0] nxt_w;
    wire logic nxt_c;
    wire logic nxt_dc;
    wire logic nxt_z;
    wire logic nxt_unsup;
    wire logic unsup_seen;
    wire logic sw_stat;

    assign sw_stat = apb_wr & hit_stat;
    assign nxt_w = commit_w ? res_ff : ((apb_wr & hit_w) ? pwdata[7:0] : w_ff);
    assign nxt_c = commit_cdc ? res_c_ff :
                   (sw_stat ? pwdata[`AAD_STAT_CARRY] : flag_c_ff);
    assign nxt_dc = commit_cdc ? res_dc_ff :
                    (sw_stat ? pwdata[`AAD_STAT_NIBBLE] : flag_dc_ff);
    // Zero follows every committed op, and ANDs touch nothing else
    assign nxt_z = commit ? res_z_ff :
                   (sw_stat ? pwdata[`AAD_STAT_ZERO] : flag_z_ff);
    // Unsupported words are dropped but remembered; set beats a clear
    assign unsup_seen = in_q4 & busy_ff & (op_ff == AAD_OP_NONE);
    assign nxt_unsup = unsup_seen | (unsup_ff & ~(sw_stat & pwdata[`AAD_STAT_UNSUP]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_ff <= `AAD_RST_WREG;
            {flag_z_ff, flag_dc_ff, flag_c_ff} <= `AAD_RST_FLAGS;
            unsup_ff <= 1'b0;
        end else if (ce) begin
            w_ff <= nxt_w;
            flag_c_ff <= nxt_c;
            flag_dc_ff <= nxt_dc;
            flag_z_ff <= nxt_z;
            unsup_ff <= nxt_unsup;
        end
    end

    // Control and retired-instruction count
    wire logic [CNT_W-1:0] nxt_retired;
    wire logic nxt_run;

    assign nxt_run = (apb_wr & hit_ctrl) ? pwdata[`AAD_CTRL_RUN] : run_ff;
    // Software cannot load the count; it moves only on a commit
    assign nxt_retired = commit ? retired_ff + CNT_W'(1) : retired_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= `AAD_RST_RUN;
            retired_ff <= `AAD_RST_RETIRED;
        end else if (ce) begin
            run_ff <= nxt_run;
            retired_ff <= nxt_retired;
        end
    end

    // Read mux
    wire logic [31:0] rd_stat;
    wire logic [31:0] rd_ctrl;

    assign rd_stat = {28'h0000000, unsup_ff, flag_z_ff, flag_dc_ff, flag_c_ff};
    assign rd_ctrl = {31'h00000000, run_ff};
    assign prdata = hit_w ? {24'h000000, w_ff} :
                    hit_stat ? rd_stat :
                    hit_ctrl ? rd_ctrl :
                    hit_ret ? 32'(retired_ff) : 32'h00000000;

endmodule : aad_core
`default_nettype wire

// file: core/aad_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "aad_regs.svh"

module aad_decode import aad_pkg::*; (
    // Instruction word
    input wire logic [13:0] instr_word,
    // Decoded fields
    output aad_op_t op,
    output logic dest_file,
    output logic [6:0] addr,
    output logic [7:0] literal
);

    wire logic is_add_lit;
    wire logic is_and_lit;
    wire logic is_add_file;
    wire logic is_and_file;

    assign is_add_lit = (instr_word[13:9] == `AAD_PFX_ADD_LIT);
    assign is_and_lit = (instr_word[13:8] == `AAD_PFX_AND_LIT);
    assign is_add_file = (instr_word[13:8] == `AAD_PFX_ADD_FILE);
    assign is_and_file = (instr_word[13:8] == `AAD_PFX_AND_FILE);

    assign op = is_add_lit ? AAD_OP_ADD_LIT :
                is_and_lit ? AAD_OP_AND_LIT :
                is_add_file ? AAD_OP_ADD_FILE :
                is_and_file ? AAD_OP_AND_FILE : AAD_OP_NONE;
    assign dest_file = instr_word[7];
    assign addr = instr_word[6:0];
    assign literal = instr_word[7:0];

endmodule : aad_decode
`default_nettype wire

// file: inc/aad_pkg.sv
package aad_pkg;

    typedef enum logic [2:0] {
        AAD_OP_NONE = 3'h0,
        AAD_OP_ADD_LIT = 3'h1,
        AAD_OP_AND_LIT = 3'h2,
        AAD_OP_ADD_FILE = 3'h3,
        AAD_OP_AND_FILE = 3'h4
    } aad_op_t;

    // Gray coded instruction-cycle phases
    typedef enum logic [1:0] {
        AAD_Q1 = 2'h0,
        AAD_Q2 = 2'h1,
        AAD_Q3 = 2'h3,
        AAD_Q4 = 2'h2
    } aad_phase_t;

endpackage : aad_pkg

// file: inc/aad_regs.svh
`ifndef AAD_REGS_SVH
`define AAD_REGS_SVH

// Register byte offsets
`define AAD_OFS_WREG 12'h000
`define AAD_OFS_STAT 12'h004
`define AAD_OFS_CTRL 12'h008
`define AAD_OFS_RETIRED 12'h00c

// Status field positions
`define AAD_STAT_CARRY 0
`define AAD_STAT_NIBBLE 1
`define AAD_STAT_ZERO 2
`define AAD_STAT_UNSUP 3

// Control field positions
`define AAD_CTRL_RUN 0

// Reset values
`define AAD_RST_WREG 8'h00
`define AAD_RST_FLAGS 3'h0
`define AAD_RST_RUN 1'b1
`define AAD_RST_RETIRED 16'h0000

// Opcode prefixes
`define AAD_PFX_ADD_LIT 5'h1f
`define AAD_PFX_AND_LIT 6'h39
`define AAD_PFX_ADD_FILE 6'h07
`define AAD_PFX_AND_FILE 6'h05

// Oscillator periods per instruction cycle
`define AAD_PERIODS_PER_CYCLE 4

`endif

// file: sim/aad_core_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "aad_regs.svh"
module aad_core_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Instruction and file ports
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic instr_ready,
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    input wire logic file_wr_en,
    input wire logic exec_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic take = instr_valid && instr_ready && ce;
    wire logic [5:0] pfx = instr_word[13:8];
    wire logic [6:0] fa = instr_word[6:0];
    wire logic lit = pfx[5:1] == `AAD_PFX_ADD_LIT || pfx == `AAD_PFX_AND_LIT;
    wire logic fil = pfx == `AAD_PFX_ADD_FILE || pfx == `AAD_PFX_AND_FILE;
    wire logic sup = take && (lit || fil);
    sequence s_lit;
        take && lit;
    endsequence
    sequence s_fil(d);
        take && fil && instr_word[7] == d;
    endsequence
    sequence s_read;
        file_rd_en [*2] ##1 !file_rd_en;
    endsequence
    a_lit_done: assert property (s_lit |-> ##3 exec_done) else $error("literal op late");
    a_lit_noread: assert property (s_lit |=> !file_rd_en [*3]) else $error("literal read");
    a_fil_read: assert property (take && fil |=> s_read) else $error("file read window");
    a_fil_done: assert property (take && fil |-> ##3 exec_done) else $error("file op late");
    a_dest_file: assert property (s_fil(1'b1) |-> ##3 file_wr_en) else $error("no write");
    a_dest_acc: assert property (s_fil(1'b0) |-> ##3 !file_wr_en) else $error("bad write");
    a_ready_gap: assert property (take |=> !instr_ready [*3]) else $error("ready in Q2-Q4");
    a_done_cause: assert property (exec_done |-> $past(sup, 3)) else $error("stray done");
    a_done_pulse: assert property (exec_done |=> !exec_done) else $error("done too long");
    a_wr_addr: assert property (file_wr_en |-> exec_done && file_addr == $past(fa, 3))
        else $error("write address wrong");
endmodule : aad_core_monitor
`default_nettype wire

// file: sim/aad_file_model.sv
`timescale 1ns/10ps
`default_nettype none
module aad_file_model (
    // Clock
    input wire logic pclk,
    // File register port
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    output logic [7:0] file_rd_data,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data
);
    logic [7:0] mem [128];
    logic [7:0] last = 8'h00;
    // Idle bus shows the inverse so a stale sample cannot pass by luck
    assign file_rd_data = file_rd_en ? mem[file_addr] : ~last;
    always @(posedge pclk) begin
        if (file_rd_en)
            last <= mem[file_addr];
        if (file_wr_en)
            mem[file_addr] <= file_wr_data;
    end
endmodule : aad_file_model
`default_nettype wire

// file: sim/test_add_and_alu_instr_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "aad_regs.svh"
module test_add_and_alu_instr_decode;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, instr_valid = 1'b0, instr_ready, file_rd_en, file_wr_en, exec_done;
    logic [13:0] instr_word = 14'h0, iw;
    logic [6:0] file_addr;
    logic [7:0] file_rd_data, file_wr_data, w = 8'h00, fmem [128];
    logic c = 1'b0, dc = 1'b0, z = 1'b0, u = 1'b0;
    logic [32:0] q_rd [$];
    logic [14:0] q_wr [$];
    logic [31:0] k;
    int n_mismatch = 0, checks = 0, cyc = 0, seed = 32'hbd53, n_done = 0, n_ret = 0;
    aad_core dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_valid, .instr_word, .instr_ready, .file_addr, .file_rd_en,
        .file_rd_data, .file_wr_en, .file_wr_data, .exec_done);
    aad_file_model fm (.pclk, .file_addr, .file_rd_en, .file_rd_data, .file_wr_en, .file_wr_data);
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    task automatic cmp(string what, logic [32:0] exp, logic [32:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && cyc < 20000);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(logic [11:0] a, logic [32:0] exp);
        q_rd.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic chk;
        repeat (4) @(posedge pclk);
        rd(`AAD_OFS_WREG, {25'h0, w});
        rd(`AAD_OFS_STAT, {29'h0, u, z, dc, c});
    endtask : chk
    task automatic setw(logic [7:0] v);
        apb(1'b1, `AAD_OFS_WREG, {24'h0, v});
        w = v;
    endtask : setw
    // Reference behaviour of one taken word
    task automatic exe(logic [13:0] x);
        logic [8:0] s;
        logic [7:0] o;
        logic fil, add;
        instr_valid <= 1'b1;
        instr_word <= x;
        do @(posedge pclk); while (instr_ready !== 1'b1 && cyc < 20000);
        instr_valid <= 1'b0;
        @(posedge pclk);
        fil = x[13:12] == 2'b00;
        add = fil ? x[9] : x[10];
        if (!(x[13:9] == `AAD_PFX_ADD_LIT || x[13:8] == `AAD_PFX_AND_LIT
            || x[13:8] == `AAD_PFX_ADD_FILE || x[13:8] == `AAD_PFX_AND_FILE)) begin
            u = 1'b1;
            return;
        end
        o = fil ? fmem[x[6:0]] : x[7:0];
        s = add ? w + o : {1'b0, w & o};
        z = s[7:0] == 8'h00;
        if (add) begin
            c = s[8];
            dc = {1'b0, w[3:0]} + o[3:0] > 5'h0f;
        end
        if (fil && x[7]) begin
            fmem[x[6:0]] = s[7:0];
            q_wr.push_back({x[6:0], s[7:0]});
        end else
            w = s[7:0];
        n_ret++;
    endtask : exe
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            cmp("apb read", q_rd.pop_front(), {pslverr, prdata});
        if (file_wr_en === 1'b1)
            cmp("file write", q_wr.pop_front(), {file_addr, file_wr_data});
        if (exec_done === 1'b1)
            n_done++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        for (int i = 0; i < 128; i++) begin
            fmem[i] = i == 17 ? 8'hc2 : 8'($random(seed));
            fm.mem[i] = fmem[i];
        end
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk;
        rd(`AAD_OFS_CTRL, 33'h1);
        rd(12'h010, 33'h1_0000_0000);
        $display("test reset ends");
        // Worked cases, carry boundaries, then a pair with no gap
        setw(8'h10); exe(14'h3e15); chk;
        setw(8'ha3); exe(14'h395f); chk;
        setw(8'h17); exe(14'h0711); chk;
        setw(8'h17); exe(14'h0591); chk;
        setw(8'hff); exe(14'h3f01); chk;
        setw(8'h0f); exe(14'h3e01); exe(14'h0791); chk;
        $display("test directed ends");
        for (int i = 0; i < 60; i++) begin
            k = $random(seed);
            case (k[9:8])
                2'd0: iw = {`AAD_PFX_ADD_LIT, k[10], k[7:0]};
                2'd1: iw = {`AAD_PFX_AND_LIT, k[7:0]};
                2'd2: iw = {`AAD_PFX_ADD_FILE, k[7:0]};
                default: iw = {`AAD_PFX_AND_FILE, k[7:0]};
            endcase
            exe(iw);
            if (k[11])
                chk;
        end
        chk;
        $display("test random ends");
        exe(14'h0000); exe(14'h3a55); exe(14'h0233); chk;
        apb(1'b1, `AAD_OFS_STAT, {28'h0, 1'b1, z, dc, c});
        u = 1'b0;
        apb(1'b1, `AAD_OFS_RETIRED, 32'hffff);
        chk;
        rd(`AAD_OFS_RETIRED, 33'(n_ret));
        cmp("done count", 33'(n_ret), 33'(n_done));
        $display("test unsupported ends");
        apb(1'b1, `AAD_OFS_CTRL, 32'h0);
        repeat (6) @(posedge pclk);
        cmp("instr_ready", 33'h0, {32'h0, instr_ready});
        apb(1'b1, `AAD_OFS_CTRL, 32'h1);
        ce <= 1'b0;
        @(posedge pclk);
        cmp("pready", 33'h0, {32'h0, pready});
        ce <= 1'b1;
        setw(8'h01); exe(14'h07a0); chk;
        cmp("queues", 33'h0, 33'(q_rd.size() + q_wr.size()));
        $display("test stall ends");
        tally_and_finish;
    end
endmodule : test_add_and_alu_instr_decode
bind aad_core aad_core_monitor mon (.pclk, .presetn, .ce, .instr_valid, .instr_word, .instr_ready,
    .file_addr, .file_rd_en, .file_wr_en, .exec_done);
`default_nettype wire
